//--- hw/sfc_consts.vh
// Constants of the serial flash command front end.
// Included by the front end design file; definitions only.
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH

// Read opcodes, idle-polarity set and mode 0/3 set
`define SFC_OP_CRD_A  8'h68
`define SFC_OP_CRD_B  8'hE8
`define SFC_OP_PRD_A  8'h52
`define SFC_OP_PRD_B  8'hD2
`define SFC_OP_B1RD_A 8'h54
`define SFC_OP_B1RD_B 8'hD4
`define SFC_OP_B2RD_A 8'h56
`define SFC_OP_B2RD_B 8'hD6
`define SFC_OP_STAT_A 8'h57
`define SFC_OP_STAT_B 8'hD7
// Buffer, program and erase opcodes
`define SFC_OP_B1WR   8'h84
`define SFC_OP_B2WR   8'h87
`define SFC_OP_B1PGE  8'h83
`define SFC_OP_B2PGE  8'h86
`define SFC_OP_B1PG   8'h88
`define SFC_OP_B2PG   8'h89
`define SFC_OP_PGER   8'h81
`define SFC_OP_BLER   8'h50
`define SFC_OP_B1THR  8'h82
`define SFC_OP_B2THR  8'h85
`define SFC_OP_B1XFR  8'h53
`define SFC_OP_B2XFR  8'h55
`define SFC_OP_B1CMP  8'h60
`define SFC_OP_B2CMP  8'h61
`define SFC_OP_B1RWR  8'h58
`define SFC_OP_B2RWR  8'h59

// Geometry
`define SFC_BUF_BYTES  9'd264
`define SFC_BUF_LAST   9'd263
`define SFC_PROT_PAGES 10'd256

// Status byte fields
`define SFC_ST_RDY 7
`define SFC_ST_CMP 6

// Frame bit counts
`define SFC_OPC_END  7'd8
`define SFC_ADDR_END 7'd32
`define SFC_BRD_END  7'd40
`define SFC_ARD_END  7'd64
`define SFC_CNT_MAX  7'h7F

`endif

//--- hw/sfc_front_end.v
// Serial flash command front end: SPI slave, opcode decoder, two page
// buffers, write FIFO, busy tracking and array engine hand-off.
// Assumes an array engine on ref_clk_i that answers arr_req_o with
// arr_done_i and presents arr_rd_data_i combinationally from the
// registered read address.
`timescale 1ns/1ns
`include "sfc_consts.vh"

module sfc_fifo #(
   parameter W  = 18,
   parameter D  = 8,
   parameter AW = 3
) (
   input  wire         ref_clk_i,
   input  wire         resetn_i,
   // Fill side
   input  wire         in_valid_i,
   output wire         in_ready_o,
   input  wire [W-1:0] in_data_i,
   // Drain side
   output wire         out_valid_o,
   input  wire         out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0]   count;
   wire         push;
   wire         pop;

   assign in_ready_o  = (count != D[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr];
   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;

   always @(posedge ref_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

module sfc_front_end #(
   parameter [3:0] DENSITY  = 4'h0,
   parameter       FIFO_D   = 8,
   parameter       FIFO_AW  = 3
) (
   // Clock and power-on reset
   input  wire       ref_clk_i,
   input  wire       resetn_i,
   // Serial link pins
   input  wire       cs_n_i,
   input  wire       sck_i,
   input  wire       si_i,
   output reg        so_o,
   output reg        so_oe_o,
   // Control pins
   input  wire       dev_resetn_i,
   input  wire       wp_n_i,
   output wire       rdy_busy_o,
   output wire       rdy_busy_oe_o,
   // Array engine
   output reg        arr_req_o,
   output reg  [7:0] arr_opcode_o,
   output reg  [9:0] arr_page_o,
   output reg        arr_buf_o,
   output wire       arr_abort_o,
   input  wire       arr_done_i,
   input  wire       arr_mismatch_i,
   output reg  [9:0] arr_rd_page_o,
   output reg  [8:0] arr_rd_byte_o,
   input  wire [7:0] arr_rd_data_i,
   // Engine access to the busy buffer
   input  wire [8:0] eng_buf_addr_i,
   input  wire       eng_buf_we_i,
   input  wire [7:0] eng_buf_wdata_i,
   output reg  [7:0] eng_buf_rdata_o,
   // Status
   output reg        clock_mode_hi_o,
   output reg        wr_overflow_o
);
   localparam [2:0] C_BAD = 3'd0, C_STAT = 3'd1, C_BRD = 3'd2, C_PRD = 3'd3;
   localparam [2:0] C_CRD = 3'd4, C_BWR = 3'd5, C_ARR = 3'd6, C_THR = 3'd7;

   localparam [2:0] S_IDLE = 3'd0, S_OPC = 3'd1, S_ADDR = 3'd2, S_DUMMY = 3'd3;
   localparam [2:0] S_WDATA = 3'd4, S_RDATA = 3'd5, S_WAIT = 3'd6, S_IGN = 3'd7;

   // Synchronisers: stage 1 feeds stage 2 only
   reg [4:0] sync1;
   reg [4:0] sync2;
   reg       cs_d;
   reg       sck_d;
   wire      cs_s  = sync2[0];
   wire      sck_s = sync2[1];
   wire      si_s  = sync2[2];
   wire      rst_s = sync2[3];
   wire      wp_s  = sync2[4];
   wire      cs_fall  = cs_d & ~cs_s;
   wire      cs_rise  = ~cs_d & cs_s;
   wire      sck_rise = ~sck_d & sck_s;
   wire      sck_fall = sck_d & ~sck_s;

   reg [2:0]  state;
   reg [6:0]  bit_cnt;
   reg [31:0] sreg;
   reg [7:0]  opcode;
   reg [2:0]  cls;
   reg        cbuf;
   reg [9:0]  page;
   reg [8:0]  baddr;
   reg [6:0]  dummy_end;
   reg [7:0]  out_sreg;
   reg [2:0]  out_cnt;
   reg        busy;
   reg        busy_buf;
   reg        busy_cmp;
   reg        cmp_flag;
   reg [7:0]  buf_mem [0:527];

   wire [6:0]  nb     = bit_cnt + 7'd1;
   wire [7:0]  in_op  = {sreg[6:0], si_s};
   wire [23:0] in_adr = {sreg[22:0], si_s};
   wire [7:0]  in_byte = {sreg[6:0], si_s};
   wire [7:0]  stat_byte = {~busy, cmp_flag, DENSITY, 2'b00};

   // FIFO between serial write data and buffer storage
   reg         push;
   reg  [17:0] push_data;
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [17:0] fifo_out_data;
   wire        fifo_pop = fifo_out_valid & ~eng_buf_we_i;

   function [2:0] op_class;
      input [7:0] op;
      begin
         case (op)
            `SFC_OP_STAT_A, `SFC_OP_STAT_B:                 op_class = C_STAT;
            `SFC_OP_B1RD_A, `SFC_OP_B1RD_B,
            `SFC_OP_B2RD_A, `SFC_OP_B2RD_B:                 op_class = C_BRD;
            `SFC_OP_PRD_A, `SFC_OP_PRD_B:                   op_class = C_PRD;
            `SFC_OP_CRD_A, `SFC_OP_CRD_B:                   op_class = C_CRD;
            `SFC_OP_B1WR, `SFC_OP_B2WR:                     op_class = C_BWR;
            `SFC_OP_B1THR, `SFC_OP_B2THR:                   op_class = C_THR;
            `SFC_OP_B1PGE, `SFC_OP_B2PGE, `SFC_OP_B1PG, `SFC_OP_B2PG,
            `SFC_OP_PGER, `SFC_OP_BLER, `SFC_OP_B1XFR, `SFC_OP_B2XFR,
            `SFC_OP_B1CMP, `SFC_OP_B2CMP, `SFC_OP_B1RWR, `SFC_OP_B2RWR:
               op_class = C_ARR;
            default:                                        op_class = C_BAD;
         endcase
      end
   endfunction

   // Buffer two for these opcodes, buffer one otherwise
   function op_buf;
      input [7:0] op;
      begin
         case (op)
            `SFC_OP_B2RD_A, `SFC_OP_B2RD_B, `SFC_OP_B2WR, `SFC_OP_B2PGE,
            `SFC_OP_B2PG, `SFC_OP_B2THR, `SFC_OP_B2XFR, `SFC_OP_B2CMP,
            `SFC_OP_B2RWR: op_buf = 1'b1;
            default:       op_buf = 1'b0;
         endcase
      end
   endfunction

   // Opcodes that alter the array and so obey write protect
   function op_alters;
      input [7:0] op;
      begin
         case (op)
            `SFC_OP_B1PGE, `SFC_OP_B2PGE, `SFC_OP_B1PG, `SFC_OP_B2PG,
            `SFC_OP_PGER, `SFC_OP_BLER, `SFC_OP_B1THR, `SFC_OP_B2THR,
            `SFC_OP_B1RWR, `SFC_OP_B2RWR: op_alters = 1'b1;
            default:                      op_alters = 1'b0;
         endcase
      end
   endfunction

   function [9:0] buf_idx;
      input       sel;
      input [8:0] a;
      begin
         buf_idx = sel ? ({1'b0, a} + {1'b0, `SFC_BUF_BYTES}) : {1'b0, a};
      end
   endfunction

   function [8:0] byte_next;
      input [8:0] a;
      begin
         byte_next = (a == `SFC_BUF_LAST) ? 9'h000 : a + 9'h001;
      end
   endfunction

   // Block erase protection covers whole blocks below the limit too
   wire prot_hit = ~wp_s & op_alters(opcode) & (page < `SFC_PROT_PAGES);
   wire launch_ok = ~busy & ~prot_hit;

   assign rdy_busy_o    = 1'b0;
   assign rdy_busy_oe_o = busy;
   assign arr_abort_o   = ~rst_s;

   sfc_fifo #(
      .W  (18),
      .D  (FIFO_D),
      .AW (FIFO_AW)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (push_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (~eng_buf_we_i),
      .out_data_o  (fifo_out_data)
   );

   // Buffer storage: engine has priority, FIFO drain waits while the engine writes
   always @(posedge ref_clk_i) begin
      if (eng_buf_we_i) begin
         buf_mem[buf_idx(busy_buf, eng_buf_addr_i)] <= eng_buf_wdata_i;
      end else if (fifo_pop) begin
         buf_mem[buf_idx(fifo_out_data[17], fifo_out_data[16:8])] <= fifo_out_data[7:0];
      end
      eng_buf_rdata_o <= buf_mem[buf_idx(busy_buf, eng_buf_addr_i)];
   end

   always @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1 <= 5'h07;
         sync2 <= 5'h07;
         cs_d  <= 1'b1;
         sck_d <= 1'b1;
      end else begin
         sync1 <= {wp_n_i, dev_resetn_i, si_i, sck_i, cs_n_i};
         sync2 <= sync1;
         cs_d  <= cs_s;
         sck_d <= sck_s;
      end
   end

   always @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state           <= S_IDLE;
         bit_cnt         <= 7'h00;
         sreg            <= 32'h00000000;
         opcode          <= 8'h00;
         cls             <= C_BAD;
         cbuf            <= 1'b0;
         page            <= 10'h000;
         baddr           <= 9'h000;
         dummy_end       <= `SFC_BRD_END;
         out_sreg        <= 8'h00;
         out_cnt         <= 3'h0;
         so_o            <= 1'b0;
         so_oe_o         <= 1'b0;
         busy            <= 1'b0;
         busy_buf        <= 1'b0;
         busy_cmp        <= 1'b0;
         cmp_flag        <= 1'b0;
         clock_mode_hi_o <= 1'b1;
         wr_overflow_o   <= 1'b0;
         arr_req_o       <= 1'b0;
         arr_opcode_o    <= 8'h00;
         arr_page_o      <= 10'h000;
         arr_buf_o       <= 1'b0;
         arr_rd_page_o   <= 10'h000;
         arr_rd_byte_o   <= 9'h000;
         push            <= 1'b0;
         push_data       <= 18'h00000;
      end else if (!rst_s) begin
         state           <= S_IDLE;
         so_oe_o         <= 1'b0;
         busy            <= 1'b0;
         clock_mode_hi_o <= 1'b1;
         arr_req_o       <= 1'b0;
         push            <= 1'b0;
      end else begin
         arr_req_o <= 1'b0;
         push      <= 1'b0;
         if (busy && arr_done_i) begin
            busy <= 1'b0;
            if (busy_cmp) begin
               cmp_flag <= arr_mismatch_i;
            end
         end
         if (cs_fall) begin
            clock_mode_hi_o <= sck_s;
            state           <= S_OPC;
            bit_cnt         <= 7'h00;
            so_oe_o         <= 1'b0;
            wr_overflow_o   <= 1'b0;
         end else if (cs_rise) begin
            state   <= S_IDLE;
            so_oe_o <= 1'b0;
            // Array work starts only on a fully addressed frame
            if (((state == S_WAIT) || (state == S_WDATA && cls == C_THR)) &&
                (bit_cnt >= `SFC_ADDR_END) && launch_ok) begin
               arr_req_o    <= 1'b1;
               arr_opcode_o <= opcode;
               arr_page_o   <= page;
               arr_buf_o    <= cbuf;
               busy         <= 1'b1;
               busy_buf     <= cbuf;
               busy_cmp     <= (opcode == `SFC_OP_B1CMP) || (opcode == `SFC_OP_B2CMP);
            end
         end else if (state != S_IDLE && state != S_IGN) begin
            if (sck_rise) begin
               sreg <= {sreg[30:0], si_s};
               if (bit_cnt != `SFC_CNT_MAX) begin
                  bit_cnt <= nb;
               end
               case (state)
                  S_OPC: begin
                     if (nb == `SFC_OPC_END) begin
                        opcode <= in_op;
                        cls    <= op_class(in_op);
                        cbuf   <= op_buf(in_op);
                        out_cnt <= 3'h0;
                        if (op_class(in_op) == C_BAD) begin
                           state <= S_IGN;
                        end else if (op_class(in_op) == C_STAT) begin
                           state <= S_RDATA;
                        end else begin
                           state <= S_ADDR;
                        end
                     end
                  end
                  S_ADDR: begin
                     if (nb == `SFC_ADDR_END) begin
                        page          <= in_adr[18:9];
                        baddr         <= in_adr[8:0];
                        arr_rd_page_o <= in_adr[18:9];
                        arr_rd_byte_o <= in_adr[8:0];
                        case (cls)
                           C_BRD: begin
                              dummy_end <= `SFC_BRD_END;
                              state <= (busy && busy_buf == cbuf) ? S_IGN : S_DUMMY;
                           end
                           C_PRD, C_CRD: begin
                              dummy_end <= `SFC_ARD_END;
                              state <= busy ? S_IGN : S_DUMMY;
                           end
                           C_BWR, C_THR: begin
                              state <= (busy && busy_buf == cbuf) ? S_IGN : S_WDATA;
                           end
                           default: begin
                              state <= S_WAIT;
                           end
                        endcase
                     end
                  end
                  S_DUMMY: begin
                     if (nb == dummy_end) begin
                        state <= S_RDATA;
                     end
                  end
                  S_WDATA: begin
                     if (nb == `SFC_BRD_END) begin
                        bit_cnt   <= `SFC_ADDR_END;
                        push      <= 1'b1;
                        push_data <= {cbuf, baddr, in_byte};
                        baddr     <= byte_next(baddr);
                        if (!fifo_in_ready) begin
                           wr_overflow_o <= 1'b1;
                        end
                     end
                  end
                  default: begin
                  end
               endcase
            end else if (sck_fall && state == S_RDATA) begin
               so_oe_o <= 1'b1;
               if (out_cnt == 3'h0) begin
                  out_cnt <= 3'h7;
                  case (cls)
                     C_STAT: begin
                        so_o     <= stat_byte[7];
                        out_sreg <= {stat_byte[6:0], 1'b0};
                     end
                     C_BRD: begin
                        so_o     <= buf_mem[buf_idx(cbuf, baddr)][7];
                        out_sreg <= {buf_mem[buf_idx(cbuf, baddr)][6:0], 1'b0};
                        baddr    <= byte_next(baddr);
                     end
                     default: begin
                        so_o          <= arr_rd_data_i[7];
                        out_sreg      <= {arr_rd_data_i[6:0], 1'b0};
                        arr_rd_byte_o <= byte_next(arr_rd_byte_o);
                        if (cls == C_CRD && arr_rd_byte_o == `SFC_BUF_LAST) begin
                           arr_rd_page_o <= arr_rd_page_o + 10'h001;
                        end
                     end
                  endcase
               end else begin
                  out_cnt  <= out_cnt - 3'h1;
                  so_o     <= out_sreg[7];
                  out_sreg <= {out_sreg[6:0], 1'b0};
               end
            end
         end
      end
   end
endmodule

//--- bench/sfc_front_end_asserts.sv
// Port-level checker for the serial flash command front end.
// Sees only the top module's ports; one clock domain, bound below.
`timescale 1ns/1ns
module sfc_front_end_asserts (
   // Clock and reset
   input wire       ref_clk_i,
   input wire       resetn_i,
   // Pins
   input wire       cs_n_i,
   input wire       sck_i,
   input wire       wp_n_i,
   input wire       dev_resetn_i,
   input wire       so_o,
   input wire       so_oe_o,
   input wire       rdy_busy_oe_o,
   // Array engine and status
   input wire       arr_req_o,
   input wire [7:0] arr_opcode_o,
   input wire [9:0] arr_page_o,
   input wire       arr_abort_o,
   input wire       arr_done_i,
   input wire       clock_mode_hi_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // Transfers and compares leave the array untouched
   wire prog = !(arr_opcode_o inside {8'h53, 8'h55, 8'h60, 8'h61});
   sequence s_sel(lvl);
      $fell(cs_n_i) && sck_i == lvl ##1 (!cs_n_i && sck_i == lvl && dev_resetn_i)[*3];
   endsequence
   sequence s_rst_held;
      (!dev_resetn_i)[*4];
   endsequence
   property p_out_rel; cs_n_i[*6] |-> !so_oe_o; endproperty
   a_out_rel: assert property (p_out_rel) else $error("output driven while deselected");
   property p_out_fall; so_oe_o && $changed(so_o) |-> !$past(sck_i, 3); endproperty
   a_out_fall: assert property (p_out_fall) else $error("output changed off a clock fall");
   property p_rst_idle;
      s_rst_held |-> !so_oe_o && !rdy_busy_oe_o && clock_mode_hi_o && arr_abort_o;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("reset pin did not idle the block");
   property p_rst_resume; $rose(dev_resetn_i) |-> ##[1:5] !arr_abort_o; endproperty
   a_rst_resume: assert property (p_rst_resume) else $error("abort held after reset pin");
   property p_busy_set; arr_req_o |-> rdy_busy_oe_o; endproperty
   a_busy_set: assert property (p_busy_set) else $error("launch without busy pin");
   property p_busy_clr; arr_done_i && rdy_busy_oe_o |=> !rdy_busy_oe_o; endproperty
   a_busy_clr: assert property (p_busy_clr) else $error("busy pin held after done");
   property p_no_second; rdy_busy_oe_o && !arr_done_i |=> !arr_req_o; endproperty
   a_no_second: assert property (p_no_second) else $error("launch while busy");
   property p_wp; (!wp_n_i)[*6] ##0 (arr_req_o && prog) |-> arr_page_o >= 10'h100; endproperty
   a_wp: assert property (p_wp) else $error("protected page launched");
   property p_mode_hi; s_sel(1'b1) |-> clock_mode_hi_o; endproperty
   a_mode_hi: assert property (p_mode_hi) else $error("clock mode not high");
   property p_mode_lo; s_sel(1'b0) |-> !clock_mode_hi_o; endproperty
   a_mode_lo: assert property (p_mode_lo) else $error("clock mode not low");
endmodule
bind sfc_front_end sfc_front_end_asserts i_chk (.ref_clk_i, .resetn_i, .cs_n_i, .sck_i,
   .wp_n_i, .dev_resetn_i, .so_o, .so_oe_o, .rdy_busy_oe_o, .arr_req_o, .arr_opcode_o,
   .arr_page_o, .arr_abort_o, .arr_done_i, .clock_mode_hi_o);

//--- bench/sfc_spi_host.sv
// Host serial master model: frames commands, shifts bits MSB first.
// Driven from the bench's tasks; changes pins at clock falling edges.
`timescale 1ns/1ns
module sfc_spi_host (
   input  wire  ref_clk_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o,
   input  wire  so_i
);
   logic        idle_hi;
   logic [31:0] rdv;
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b1;
      si_o = 1'b0;
      idle_hi = 1'b1;
      rdv = 32'h0;
   end
   // Idle level of the clock picks the mode
   task sel(input logic hi);
      idle_hi = hi;
      @(negedge ref_clk_i);
      sck_o <= hi;
      repeat (4) @(negedge ref_clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(negedge ref_clk_i);
   endtask
   task bits(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge ref_clk_i);
         sck_o <= 1'b0;
         si_o <= v[i];
         repeat (4) @(negedge ref_clk_i);
         sck_o <= 1'b1;
         rdv = {rdv[30:0], so_i};
         repeat (3) @(negedge ref_clk_i);
      end
   endtask
   task desel;
      @(negedge ref_clk_i);
      sck_o <= idle_hi;
      repeat (4) @(negedge ref_clk_i);
      cs_n_o <= 1'b1;
      si_o <= ~si_o;
      repeat (8) @(negedge ref_clk_i);
   endtask
endmodule

//--- bench/sfc_front_end_tb.sv
// Bench for the serial flash command front end with host and engine models.
// Expects the design and the host model compiled before it.
`timescale 1ns/1ns
module sfc_front_end_tb;
   logic        ref_clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        dev_resetn_i = 1'b1;
   logic        wp_n_i = 1'b1;
   logic        arr_done_i = 1'b0;
   logic        arr_mismatch_i = 1'b0;
   logic        oe_seen = 1'b0;
   logic        so_last = 1'b0;
   logic        l_buf;
   logic [7:0]  l_op;
   logic [9:0]  l_pg, pg;
   wire         cs_n_i, sck_i, si_i, so_o, so_oe_o, rdy_busy_o, rdy_busy_oe_o;
   wire         arr_req_o, arr_buf_o, arr_abort_o, clock_mode_hi_o, wr_overflow_o;
   wire  [7:0]  arr_opcode_o;
   wire  [9:0]  arr_page_o, arr_rd_page_o;
   wire  [8:0]  arr_rd_byte_o;
   int          failures = 0, n_tests = 0, n_launch = 0, eng_cnt = 0, eng_dly = 20, cyc = 0;
   logic [8:0]  ops [14] = '{9'h083, 9'h186, 9'h088, 9'h189, 9'h081, 9'h050, 9'h082,
                             9'h185, 9'h053, 9'h155, 9'h060, 9'h161, 9'h058, 9'h159};
   // Released output shows the inverse of its last driven bit
   wire         so_pin = (so_oe_o === 1'b1) ? so_o : ~so_last;
   sfc_front_end #(.DENSITY(4'hA)) i_dut (.ref_clk_i, .resetn_i, .cs_n_i, .sck_i, .si_i,
      .so_o, .so_oe_o, .dev_resetn_i, .wp_n_i, .rdy_busy_o, .rdy_busy_oe_o, .arr_req_o,
      .arr_opcode_o, .arr_page_o, .arr_buf_o, .arr_abort_o, .arr_done_i, .arr_mismatch_i,
      .arr_rd_page_o, .arr_rd_byte_o, .arr_rd_data_i(arr_rd_page_o[7:0] ^ arr_rd_byte_o[7:0]),
      .eng_buf_addr_i(9'h000), .eng_buf_we_i(1'b0), .eng_buf_wdata_i(8'h00),
      .eng_buf_rdata_o(), .clock_mode_hi_o, .wr_overflow_o);
   sfc_spi_host i_host (.ref_clk_i, .cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i), .so_i(so_pin));
   always #25 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc++;
      if (so_oe_o === 1'b1) begin
         oe_seen = 1'b1;
         so_last <= so_o;
      end
      if (cyc == 60000) begin
         failures++;
         finish_test;
      end
   end
   // Array engine: records each launch, answers after eng_dly cycles
   always @(negedge ref_clk_i) begin
      arr_done_i <= 1'b0;
      if (arr_req_o === 1'b1) begin
         n_launch++;
         l_op = arr_opcode_o;
         l_pg = arr_page_o;
         l_buf = arr_buf_o;
         eng_cnt = eng_dly;
      end else if (arr_abort_o === 1'b1) eng_cnt = 0;
      else if (eng_cnt == 1) begin
         arr_done_i <= 1'b1;
         eng_cnt = 0;
      end else if (eng_cnt > 1) eng_cnt--;
   end
   function logic [23:0] ad(input logic [9:0] p, input logic [8:0] b);
      return {5'h00, p, b};
   endfunction
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task frame(input logic hi, input logic [7:0] op, input logic [23:0] a, input int na,
              input int nd, input logic [31:0] wd, input int nw, input int nr);
      i_host.sel(hi);
      oe_seen = 1'b0;
      i_host.bits({24'h0, op}, 8);
      i_host.bits({8'h0, a}, na);
      i_host.bits(32'h0, nd);
      i_host.bits(wd, nw);
      i_host.bits(32'h0, nr);
      i_host.desel;
   endtask
   task rdchk(input string nm, input logic hi, input logic [7:0] op, input logic [23:0] a,
              input int na, input int nd, input logic [15:0] exp);
      frame(hi, op, a, na, nd, 32'h0, 0, 16);
      chk(nm, {16'h0, exp}, {16'h0, i_host.rdv[15:0]});
   endtask
   task wait_rdy;
      for (int k = 0; k < 4000 && rdy_busy_oe_o !== 1'b0; k++) @(negedge ref_clk_i);
      chk("ready", 0, rdy_busy_oe_o);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      chk("mode at reset", 1, clock_mode_hi_o);
      chk("busy data", 0, rdy_busy_o);
      chk("out idle", 0, so_oe_o);
      rdchk("status 57", 1, 8'h57, 0, 0, 0, 16'hA8A8);
      rdchk("status D7", 0, 8'hD7, 0, 0, 0, 16'hA8A8);
      for (int b = 0; b < 2; b++) begin
         frame(b[0], b ? 8'h87 : 8'h84, ad(0, 9'h106), 24, 0, 32'hA1B2C3D4, 32, 0);
         rdchk("buf wrap", 1, b ? 8'h56 : 8'hD4, ad(0, 9'h106), 24, 8, 16'hA1B2);
         rdchk("buf first", 0, b ? 8'hD6 : 8'h54, ad(0, 0), 24, 8, 16'hC3D4);
      end
      chk("overflow", 0, wr_overflow_o);
      rdchk("page 52", 1, 8'h52, ad(4, 9'h107), 24, 32, 16'h0304);
      rdchk("page D2", 0, 8'hD2, ad(4, 9'h107), 24, 32, 16'h0304);
      rdchk("cont 68", 1, 8'h68, ad(2, 9'h107), 24, 32, 16'h0503);
      rdchk("cont E8", 0, 8'hE8, ad(1, 0), 24, 32, 16'h0100);
      foreach (ops[i]) begin
         pg = 10'h140 + {i[6:0], 3'h0};
         frame(i[0], ops[i][7:0], ad(pg, 0), 24, 0, 32'h0, 0, 0);
         chk("launches", i + 1, n_launch);
         chk("opcode", {24'h0, ops[i][7:0]}, {24'h0, l_op});
         chk("page", {22'h0, pg}, {22'h0, l_pg});
         if (ops[i][7:0] != 8'h81 && ops[i][7:0] != 8'h50) chk("buf", ops[i][8], l_buf);
         chk("mode", i[0], clock_mode_hi_o);
         wait_rdy;
      end
      eng_dly = 3000;
      frame(1, 8'h83, ad(10'h12C, 0), 24, 0, 32'h0, 0, 0);
      chk("busy pin", 1, rdy_busy_oe_o);
      rdchk("status busy", 1, 8'hD7, 0, 0, 0, 16'h2828);
      frame(1, 8'h81, ad(10'h12D, 0), 24, 0, 32'h0, 0, 0);
      chk("refused", 15, n_launch);
      frame(1, 8'h87, ad(0, 5), 24, 0, 32'h5A69, 16, 0);
      rdchk("other buf", 1, 8'h56, ad(0, 5), 24, 8, 16'h5A69);
      frame(1, 8'hD4, ad(0, 0), 24, 8, 32'h0, 0, 16);
      chk("busy buf", 0, oe_seen);
      wait_rdy;
      eng_dly = 20;
      arr_mismatch_i = 1'b1;
      frame(0, 8'h61, ad(7, 0), 24, 0, 32'h0, 0, 0);
      wait_rdy;
      rdchk("cmp flag", 1, 8'h57, 0, 0, 0, 16'hE8E8);
      arr_mismatch_i = 1'b0;
      wp_n_i = 1'b0;
      frame(1, 8'h88, ad(10'h0FF, 0), 24, 0, 32'h0, 0, 0);
      frame(1, 8'h50, ad(10'h0F8, 0), 24, 0, 32'h0, 0, 0);
      chk("protected", 16, n_launch);
      frame(1, 8'h88, ad(10'h100, 0), 24, 0, 32'h0, 0, 0);
      wait_rdy;
      chk("unprotected", 17, n_launch);
      wp_n_i = 1'b1;
      frame(1, 8'hFF, ad(0, 0), 24, 8, 32'h0, 0, 16);
      chk("unknown op", 0, oe_seen);
      eng_dly = 3000;
      frame(0, 8'h81, ad(10'h190, 0), 24, 0, 32'h0, 0, 0);
      dev_resetn_i = 1'b0;
      repeat (6) @(negedge ref_clk_i);
      chk("abort", 1, arr_abort_o);
      chk("busy abort", 0, rdy_busy_oe_o);
      chk("mode reset", 1, clock_mode_hi_o);
      dev_resetn_i = 1'b1;
      eng_dly = 20;
      repeat (4) @(negedge ref_clk_i);
      frame(1, 8'hD7, 0, 0, 0, 32'h0, 0, 8);
      chk("resume ready", 1, i_host.rdv[7]);
      frame(1, 8'h83, ad(10'h12C, 0), 24, 0, 32'h0, 0, 0);
      chk("resume launch", 19, n_launch);
      wait_rdy;
      finish_test;
   end
endmodule
